// file: jtp_tap_controller.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE_01 - Sixteen-state machine selects register operation.
// RULE_02 - Transitions decided by mode select at rising edge.
// RULE_03 - Power on or test reset enters reset state.
// RULE_04 - Five mode-select-high edges reach reset state.
// RULE_05 - Test reset line may stay unconnected.
// RULE_06 - Reset state loads identification instruction.
// RULE_07 - Idle holds while select low, registers unchanged.
// RULE_08 - Select and exit states only branch.
// RULE_09 - Capture-DR loads pin and core levels.
// RULE_10 - Capture-IR loads fixed status word.
// RULE_11 - Shift moves one bit per test clock.
// RULE_12 - Shift continues; last bit leaves entering Exit1.
// RULE_13 - Pause holds shift contents while select low.
// RULE_14 - Update-DR moves stages into holding latches.
// RULE_15 - Update-IR writes new instruction, effective immediately.
// RULE_16 - Instruction register serial only in IR states.
// RULE_17 - Bypass passes serial input to output.
// RULE_18 - Inputs sampled rising, output changes falling.
// RULE_19 - Bypass is one stage, one clock delay.
// RULE_20 - Instruction selects data register in DR states.
// RULE_21 - Arcs follow the standard state diagram.
// RULE_22 - Active-low test reset forces reset state independently.
// RULE_23 - Serial output driven only in shift states.
module jtp_tap_controller
    import jtp_pkg::*;
(
    // System clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Test access pins, asynchronous to clk
    input  wire logic                    tck,
    input  wire logic                    tms,
    input  wire logic                    tdi,
    input  wire logic                    trstN,
    output logic                         tdo,
    output logic                         tdoOe,
    // Device pins and core logic seen through the boundary chain
    input  wire logic [BS_IN_CELLS-1:0]  pinIn,
    output logic      [BS_IN_CELLS-1:0]  coreIn,
    input  wire logic [BS_OUT_CELLS-1:0] coreOut,
    output logic      [BS_OUT_CELLS-1:0] pinOut,
    // Status
    output logic      [IR_LEN-1:0]       instrOut,
    output logic      [3:0]              stateOut
);

    // Two-flop synchronisers for every pin input.
    logic [SYNC_STAGES-1:0]              tckSync_q;
    logic [SYNC_STAGES-1:0]              tmsSync_q;
    logic [SYNC_STAGES-1:0]              tdiSync_q;
    logic [SYNC_STAGES-1:0]              trstSync_q;
    logic [BS_IN_CELLS-1:0]              pinMeta_q;
    logic [BS_IN_CELLS-1:0]              pinSync_q;
    logic                                tckPrev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tckSync_q  <= '0;
            tmsSync_q  <= '1;
            tdiSync_q  <= '1;
            trstSync_q <= '0;
            pinMeta_q  <= '0;
            pinSync_q  <= '0;
            tckPrev_q  <= 1'b0;
        end else begin
            tckSync_q  <= {tckSync_q[0], tck};
            tmsSync_q  <= {tmsSync_q[0], tms};
            tdiSync_q  <= {tdiSync_q[0], tdi};
            trstSync_q <= {trstSync_q[0], trstN};
            pinMeta_q  <= pinIn;
            pinSync_q  <= pinMeta_q;
            tckPrev_q  <= tckSync_q[1];
        end
    end

    // Edge strobes and sampled pin levels.
    wire tckHigh  = tckSync_q[1];
    wire tckRise  = tckHigh & ~tckPrev_q;                                   // [RULE_02] [RULE_18]
    wire tckFall  = ~tckHigh & tckPrev_q;                                   // [RULE_18]
    wire tmsBit   = tmsSync_q[1];
    wire tdiBit   = tdiSync_q[1];
    // Test reset is honoured whenever low, with or without test clock edges; a floating
    // line is expected to be pulled high on the board, so mode-select reset still works.
    wire trstHold = ~trstSync_q[1];                                         // [RULE_22] [RULE_05]

    // State machine.
    jtp_state_e state_q;
    jtp_state_e state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)                                               // [RULE_01] [RULE_21]
            TestLogicReset: state_d = tmsBit ? TestLogicReset : RunTestIdle;
            RunTestIdle:    state_d = tmsBit ? SelectDr : RunTestIdle;      // [RULE_07]
            SelectDr:       state_d = tmsBit ? SelectIr : CaptureDr;        // [RULE_08]
            CaptureDr:      state_d = tmsBit ? Exit1Dr : ShiftDr;
            ShiftDr:        state_d = tmsBit ? Exit1Dr : ShiftDr;           // [RULE_12]
            Exit1Dr:        state_d = tmsBit ? UpdateDr : PauseDr;          // [RULE_08]
            PauseDr:        state_d = tmsBit ? Exit2Dr : PauseDr;           // [RULE_13]
            Exit2Dr:        state_d = tmsBit ? UpdateDr : ShiftDr;          // [RULE_08]
            UpdateDr:       state_d = tmsBit ? SelectDr : RunTestIdle;
            SelectIr:       state_d = tmsBit ? TestLogicReset : CaptureIr;  // [RULE_08] [RULE_04]
            CaptureIr:      state_d = tmsBit ? Exit1Ir : ShiftIr;
            ShiftIr:        state_d = tmsBit ? Exit1Ir : ShiftIr;           // [RULE_12]
            Exit1Ir:        state_d = tmsBit ? UpdateIr : PauseIr;          // [RULE_08]
            PauseIr:        state_d = tmsBit ? Exit2Ir : PauseIr;           // [RULE_13]
            Exit2Ir:        state_d = tmsBit ? UpdateIr : ShiftIr;          // [RULE_08]
            UpdateIr:       state_d = tmsBit ? SelectDr : RunTestIdle;
        endcase
    end

    // Any state reaches reset within five high samples through the arcs above.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= TestLogicReset;                                      // [RULE_03]
        end else if (trstHold) begin
            state_q <= TestLogicReset;                                      // [RULE_03] [RULE_22]
        end else if (tckRise) begin
            state_q <= state_d;                                             // [RULE_02] [RULE_04]
        end
    end

    // State decode; each strobe lasts one clk cycle at a test clock rising edge.
    wire inReset     = (state_q == TestLogicReset);
    wire doCaptureDr = tckRise & ~trstHold & (state_q == CaptureDr);
    wire doShiftDr   = tckRise & ~trstHold & (state_q == ShiftDr);
    wire doUpdateDr  = tckRise & ~trstHold & (state_q == UpdateDr);
    wire doCaptureIr = tckRise & ~trstHold & (state_q == CaptureIr);
    wire doShiftIr   = tckRise & ~trstHold & (state_q == ShiftIr);
    wire doUpdateIr  = tckRise & ~trstHold & (state_q == UpdateIr);
    wire inShift     = (state_q == ShiftDr) | (state_q == ShiftIr);
    wire irPath      = (state_q == ShiftIr);

    // Instruction register and its shift stage.
    logic [IR_LEN-1:0] irShift_q;
    logic [IR_LEN-1:0] irShift_d;
    logic [IR_LEN-1:0] instr_q;

    assign irShift_d = doCaptureIr ? IR_STATUS_WORD :                       // [RULE_10]
                       doShiftIr   ? {tdiBit, irShift_q[IR_LEN-1:1]} :      // [RULE_11] [RULE_16]
                                     irShift_q;                             // [RULE_13]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irShift_q <= IR_STATUS_WORD;
        end else begin
            irShift_q <= irShift_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_q <= IR_RESET_VALUE;
        end else if (inReset | trstHold) begin
            instr_q <= IR_RESET_VALUE;                                      // [RULE_06]
        end else if (doUpdateIr) begin
            instr_q <= irShift_q;                                           // [RULE_15]
        end
    end

    // Instruction decode; unknown codes fall back to the bypass path.
    wire selExtest = (instr_q == INSTR_EXTEST);
    wire selSample = (instr_q == INSTR_SAMPLE);
    wire selIdcode = (instr_q == INSTR_IDCODE);
    wire selBsr    = selExtest | selSample;                                 // [RULE_20]
    wire selBypass = ~selBsr & ~selIdcode;                                  // [RULE_20]

    // Single-stage bypass register, cleared on capture.
    logic bypass_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bypass_q <= 1'b0;
        end else if (doCaptureDr & selBypass) begin
            bypass_q <= 1'b0;
        end else if (doShiftDr & selBypass) begin
            bypass_q <= tdiBit;                                             // [RULE_17] [RULE_19]
        end
    end

    // Identification shift register.
    logic [ID_LEN-1:0] idShift_q;
    logic [ID_LEN-1:0] idShift_d;

    assign idShift_d = (doCaptureDr & selIdcode) ? ID_WORD :
                       (doShiftDr & selIdcode)   ? {tdiBit, idShift_q[ID_LEN-1:1]} :   // [RULE_11]
                                                   idShift_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idShift_q <= ID_WORD;
        end else begin
            idShift_q <= idShift_d;
        end
    end

    // Boundary chain. Cell 0 sits next to the serial output.
    wire               bsCapture = doCaptureDr & selBsr;
    wire               bsShift   = doShiftDr & selBsr;
    wire               bsUpdate  = doUpdateDr & selBsr;
    wire [BS_LEN-1:0]  bsCaptureIn;
    wire [BS_LEN-1:0]  bsStage;
    wire [BS_LEN-1:0]  bsHeld;
    wire [BS_LEN:0]    bsChain;

    // Input cells capture the pin level, output cells the core's drive.
    assign bsCaptureIn = {coreOut, pinSync_q};                              // [RULE_09]
    assign bsChain[BS_LEN] = tdiBit;

    genvar g;
    generate
        for (g = 0; g < BS_LEN; g++) begin : gCell
            jtp_scan_cell i_jtp_scan_cell (
                .clk       (clk),
                .rst       (rst),
                .captureEn (bsCapture),                                     // [RULE_09]
                .shiftEn   (bsShift),                                       // [RULE_11]
                .updateEn  (bsUpdate),                                      // [RULE_14]
                .captureIn (bsCaptureIn[g]),
                .serialIn  (bsChain[g+1]),
                .shiftOut  (bsStage[g]),
                .heldOut   (bsHeld[g])
            );
            assign bsChain[g] = bsStage[g];
        end
    endgenerate

    // Pin side: the held latches drive pins only in the external test mode, so a
    // preload never disturbs the pins before the instruction takes effect.
    wire [BS_OUT_CELLS-1:0] pinOut_d  = selExtest ? bsHeld[BS_LEN-1:BS_IN_CELLS] : coreOut;   // [RULE_14]
    logic [BS_OUT_CELLS-1:0] pinOut_q;
    logic [BS_IN_CELLS-1:0]  coreIn_q;
    wire [BS_IN_CELLS-1:0]  coreIn_d  = selExtest ? bsHeld[BS_IN_CELLS-1:0] : pinSync_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut_q <= '0;
            coreIn_q <= '0;
        end else begin
            pinOut_q <= pinOut_d;
            coreIn_q <= coreIn_d;
        end
    end

    // Serial output selection.
    wire drSerial = selBsr    ? bsStage[0] :
                    selIdcode ? idShift_q[0] :
                                bypass_q;                                   // [RULE_20]
    wire tdo_d    = irPath ? irShift_q[0] : drSerial;                       // [RULE_16]

    // Output stage is updated on test clock falling edges, and cleared while test reset is low.
    logic tdo_q;
    logic tdoOe_q;

    // The data bit is forced low outside the shift states, so a stale bit never leaks out.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo_q <= TDO_RESET;
        end else if (trstHold) begin
            tdo_q <= TDO_RESET;
        end else if (tckFall) begin
            tdo_q <= inShift ? tdo_d : TDO_RESET;                           // [RULE_18] [RULE_12]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdoOe_q <= OE_RESET;
        end else if (trstHold) begin
            tdoOe_q <= OE_RESET;                                            // [RULE_23]
        end else if (tckFall) begin
            tdoOe_q <= inShift;                                             // [RULE_23]
        end
    end

    // Status outputs, registered.
    logic [3:0] stateOut_q;
    logic [IR_LEN-1:0] instrOut_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateOut_q <= 4'h0;
            instrOut_q <= IR_RESET_VALUE;
        end else begin
            stateOut_q <= state_q;
            instrOut_q <= instr_q;
        end
    end

    assign tdo      = tdo_q;
    assign tdoOe    = tdoOe_q;
    assign pinOut   = pinOut_q;
    assign coreIn   = coreIn_q;
    assign stateOut = stateOut_q;
    assign instrOut = instrOut_q;

endmodule // jtp_tap_controller

`default_nettype wire

// file: jtp_pkg.sv
package jtp_pkg;

    // Controller states.
    typedef enum logic [3:0] {
        TestLogicReset,
        RunTestIdle,
        SelectDr,
        CaptureDr,
        ShiftDr,
        Exit1Dr,
        PauseDr,
        Exit2Dr,
        UpdateDr,
        SelectIr,
        CaptureIr,
        ShiftIr,
        Exit1Ir,
        PauseIr,
        Exit2Ir,
        UpdateIr
    } jtp_state_e;

    // Instruction register geometry and codes.
    localparam int             IR_LEN         = 4;
    localparam logic [3:0]     INSTR_EXTEST   = 4'h0;
    localparam logic [3:0]     INSTR_IDCODE   = 4'h1;
    localparam logic [3:0]     INSTR_SAMPLE   = 4'h2;
    localparam logic [3:0]     INSTR_BYPASS   = 4'hf;
    localparam logic [3:0]     IR_STATUS_WORD = 4'h5;
    localparam logic [3:0]     IR_RESET_VALUE = INSTR_IDCODE;

    // Identification word; the value is arbitrary, bit 0 must stay one.
    localparam int             ID_LEN         = 32;
    localparam logic [31:0]    ID_WORD        = 32'h0000_a001;

    // Boundary chain: input cells first (nearest the serial output), then output cells.
    localparam int             BS_IN_CELLS    = 4;
    localparam int             BS_OUT_CELLS   = 4;
    localparam int             BS_LEN         = BS_IN_CELLS + BS_OUT_CELLS;

    // Pin synchroniser depth.
    localparam int             SYNC_STAGES    = 2;

    // Reset values.
    localparam logic           TDO_RESET      = 1'b0;
    localparam logic           OE_RESET       = 1'b0;

endpackage : jtp_pkg

// file: jtp_scan_cell.sv
`timescale 1ns/10ps
`default_nettype none

// One boundary cell: a capture/shift stage followed by an update latch.
module jtp_scan_cell (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Controls, each a one-cycle strobe
    input  wire logic captureEn,
    input  wire logic shiftEn,
    input  wire logic updateEn,
    // Data
    input  wire logic captureIn,
    input  wire logic serialIn,
    output logic      shiftOut,
    output logic      heldOut
);

    logic stage_q;
    logic stage_d;
    logic held_q;

    assign stage_d = captureEn ? captureIn : (shiftEn ? serialIn : stage_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_q <= 1'b0;
        end else if (updateEn) begin
            held_q <= stage_q;
        end
    end

    assign shiftOut = stage_q;
    assign heldOut  = held_q;

endmodule // jtp_scan_cell

`default_nettype wire

// file: jtp_tap_controller_props.sv
`timescale 1ns/10ps
`default_nettype none

module jtp_tap_controller_props
    import jtp_pkg::*;
(
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rst,
    // Link
    input wire logic                    tck,
    input wire logic                    tms,
    input wire logic                    tdi,
    input wire logic                    trstN,
    input wire logic                    tdo,
    input wire logic                    tdoOe,
    // Boundary
    input wire logic [BS_IN_CELLS-1:0]  pinIn,
    input wire logic [BS_IN_CELLS-1:0]  coreIn,
    input wire logic [BS_OUT_CELLS-1:0] coreOut,
    input wire logic [BS_OUT_CELLS-1:0] pinOut,
    // Status
    input wire logic [IR_LEN-1:0]       instrOut,
    input wire logic [3:0]              stateOut
);
    logic       tckPrev_q;
    logic       tckRise;
    logic [2:0] ones_q;
    logic [2:0] ones_d;
    logic [2:0] settle_q;
    logic [2:0] settle_d;

    // Counts consecutive test clock rises with mode select high, saturating at five.
    assign tckRise  = tck & ~tckPrev_q;
    assign ones_d   = !tckRise ? ones_q : !tms ? 3'h0 : (ones_q == 3'h5) ? ones_q : ones_q + 3'h1;
    assign settle_d = (settle_q == 3'h7) ? settle_q : settle_q + 3'h1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tckPrev_q <= 1'b0;
            ones_q    <= 3'h0;
            settle_q  <= 3'h0;
        end else begin
            tckPrev_q <= tck;
            ones_q    <= ones_d;
            settle_q  <= settle_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_tdo_idle; !tdoOe |-> !tdo; endproperty
    property p_oe_rise; $rose(tdoOe) |-> stateOut inside {ShiftDr, ShiftIr}; endproperty
    property p_trst;
        !trstN [*6] |-> stateOut == TestLogicReset && instrOut == INSTR_IDCODE && !tdoOe;
    endproperty
    property p_tck_step; $changed(stateOut) && trstN && $past(trstN) |-> tck; endproperty
    property p_five; $rose(ones_q == 3'h5) |-> ##[1:10] stateOut == TestLogicReset; endproperty
    property p_idle_hold;
        stateOut == RunTestIdle && $past(stateOut) == RunTestIdle && $past(stateOut, 2) == RunTestIdle
            |-> $stable(instrOut);
    endproperty
    property p_instr_src;
        $changed(instrOut) |-> stateOut inside {RunTestIdle, SelectDr, TestLogicReset} || $past(stateOut) == UpdateIr;
    endproperty
    property p_pass;
        (instrOut != INSTR_EXTEST) [*2] ##0 settle_q == 3'h7 |-> pinOut == $past(coreOut);
    endproperty
    property p_ext_hold;
        instrOut == INSTR_EXTEST && trstN && stateOut inside {CaptureDr, ShiftDr, Exit1Dr, PauseDr, Exit2Dr}
            |-> $stable(pinOut);
    endproperty

    a_tdo_idle: assert property (p_tdo_idle) else $error("tdo high while disabled");
    a_oe_rise: assert property (p_oe_rise) else $error("tdo enabled outside shift");
    a_trst: assert property (p_trst) else $error("test reset not applied");
    a_tck_step: assert property (p_tck_step) else $error("state moved without tck rise");
    a_five: assert property (p_five) else $error("five ones did not reset");
    a_idle_hold: assert property (p_idle_hold) else $error("instruction moved in idle");
    a_instr_src: assert property (p_instr_src) else $error("instruction moved off update");
    a_pass: assert property (p_pass) else $error("pins not following core");
    a_ext_hold: assert property (p_ext_hold) else $error("pins changed before update");

    c_ir_update: cover property (stateOut == UpdateIr);
    c_pause: cover property (stateOut == PauseDr);
    c_five: cover property (ones_q == 3'h5);
    c_trst: cover property (!trstN [*6]);
endmodule : jtp_tap_controller_props

bind jtp_tap_controller jtp_tap_controller_props i_jtp_tap_controller_props (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe),
    .pinIn(pinIn), .coreIn(coreIn), .coreOut(coreOut), .pinOut(pinOut), .instrOut(instrOut), .stateOut(stateOut)
);

`default_nettype wire

// file: jtp_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host test controller; the test clock stands low between frames.
module jtp_host_model (
    // Link
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trstN,
    input  wire logic tdoLine
);
    initial begin
        tck   = 1'b0;
        tms   = 1'b1;
        tdi   = 1'b0;
        trstN = 1'b1;
    end

    // One test clock period; tdo is taken just before the rise.
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #62.5;
        o   = tdoLine;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask

    task automatic tmsReset();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
    endtask

    task automatic pulseTrst();
        trstN = 1'b0;
        #100;
        trstN = 1'b1;
        #20;
    endtask
endmodule : jtp_host_model

`default_nettype wire

// file: jtp_tap_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failCount++; \
    $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end

module jtp_tap_controller_tb
    import jtp_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  pinIn = 4'h0;
    logic [3:0]  coreOut = 4'h0;
    wire         tck, tms, tdi, trstN, tdoLine;
    logic        tdo, tdoOe;
    logic [3:0]  coreIn, pinOut, instrOut, stateOut;
    logic [31:0] d;
    int          failCount = 0;
    int          comparisons = 0;

    always #2 clk = ~clk;
    // The host sees a pulled-up line when tdo is not driven.
    assign tdoLine = tdoOe ? tdo : 1'b1;

    jtp_tap_controller i_jtp_tap_controller (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .pinIn(pinIn), .coreIn(coreIn), .coreOut(coreOut),
        .pinOut(pinOut), .instrOut(instrOut), .stateOut(stateOut));
    jtp_host_model i_jtp_host_model (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdoLine(tdoLine));

    // Scans from idle back to idle; a nonzero pauseAt parks in Pause after that many bits.
    task automatic scan(input bit isIr, input int n, input logic [31:0] din, input int pauseAt,
                        output logic [31:0] dout);
        logic o;
        int   i;
        dout = 32'h0;
        i_jtp_host_model.step(1'b1, 1'b0, o);
        if (isIr) i_jtp_host_model.step(1'b1, 1'b0, o);
        i_jtp_host_model.step(1'b0, 1'b0, o);
        i_jtp_host_model.step(1'b0, 1'b0, o);
        for (i = 0; i < n; i++) begin
            i_jtp_host_model.step(i == n - 1 || i == pauseAt - 1, din[i], o);
            dout[i] = o;
            if (i == pauseAt - 1 && i != n - 1) begin
                repeat (3) i_jtp_host_model.step(1'b0, 1'b0, o);
                `CHK("pause state", isIr ? PauseIr : PauseDr, stateOut)
                `CHK("pause oe", 1'b0, tdoOe)
                i_jtp_host_model.step(1'b1, 1'b0, o);
                i_jtp_host_model.step(1'b0, 1'b0, o);
            end
        end
        i_jtp_host_model.step(1'b1, 1'b0, o);
        i_jtp_host_model.step(1'b0, 1'b0, o);
    endtask

    task automatic testResetIdle();
        logic o;
        `CHK("reset state", TestLogicReset, stateOut)
        `CHK("reset instr", INSTR_IDCODE, instrOut)
        repeat (4) i_jtp_host_model.step(1'b0, 1'b1, o);
        `CHK("idle state", RunTestIdle, stateOut)
        `CHK("idle instr", INSTR_IDCODE, instrOut)
    endtask

    task automatic testIrBypass();
        scan(1'b1, IR_LEN, INSTR_BYPASS, 0, d);
        `CHK("ir capture", IR_STATUS_WORD, d[3:0])
        `CHK("ir update", INSTR_BYPASS, instrOut)
        scan(1'b0, 6, 32'h2d, 3, d);
        `CHK("bypass out", 6'h1a, d[5:0])
    endtask

    task automatic testIdcode();
        logic o;
        i_jtp_host_model.step(1'b1, 1'b0, o);
        i_jtp_host_model.step(1'b0, 1'b0, o);
        i_jtp_host_model.step(1'b0, 1'b0, o);
        i_jtp_host_model.tmsReset();
        `CHK("tms reset", TestLogicReset, stateOut)
        `CHK("tms reset instr", INSTR_IDCODE, instrOut)
        i_jtp_host_model.step(1'b0, 1'b0, o);
        scan(1'b0, ID_LEN, 32'h0, 0, d);
        `CHK("id word", ID_WORD, d)
    endtask

    task automatic testBoundary();
        @(posedge clk);
        #1;
        pinIn = 4'ha;
        coreOut = 4'h6;
        scan(1'b1, IR_LEN, INSTR_SAMPLE, 0, d);
        `CHK("sample pins", 4'h6, pinOut)
        scan(1'b0, BS_LEN, 32'h3c, 0, d);
        `CHK("sample capture", 8'h6a, d[7:0])
        `CHK("preload pins", 4'h6, pinOut)
        scan(1'b1, IR_LEN, INSTR_EXTEST, 2, d);
        `CHK("ir pause capture", IR_STATUS_WORD, d[3:0])
        `CHK("extest pins", 4'h3, pinOut)
        `CHK("extest core", 4'hc, coreIn)
        scan(1'b0, BS_LEN, 32'h81, 5, d);
        `CHK("extest capture", 8'h6a, d[7:0])
        `CHK("update pins", 4'h8, pinOut)
        `CHK("update core", 4'h1, coreIn)
    endtask

    task automatic testTrst();
        logic o;
        i_jtp_host_model.step(1'b1, 1'b0, o);
        i_jtp_host_model.step(1'b0, 1'b0, o);
        i_jtp_host_model.step(1'b0, 1'b0, o);
        i_jtp_host_model.pulseTrst();
        `CHK("trst state", TestLogicReset, stateOut)
        `CHK("trst instr", INSTR_IDCODE, instrOut)
        `CHK("trst oe", 1'b0, tdoOe)
        `CHK("trst pins", 4'h6, pinOut)
    endtask

    task automatic endOfTest();
        $display("comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (8) @(posedge clk);
        testResetIdle();
        testIrBypass();
        testIdcode();
        testBoundary();
        testTrst();
        endOfTest();
    end

    initial begin
        #100000;
        failCount++;
        endOfTest();
    end
endmodule : jtp_tap_controller_tb

`default_nettype wire
